// >>> design/frint_defines.svh
// constants for the feedback restart interlock
//****************************************************************
//****************************************************************
`ifndef FRINT_DEFINES_SVH
`define FRINT_DEFINES_SVH
`define FRINT_CLK_HZ        25000000
`define FRINT_T_ON_MS       350
`define FRINT_T_OFF_MS      100
`define FRINT_ON_CYC  ((`FRINT_CLK_HZ / 1000) * `FRINT_T_ON_MS)
`define FRINT_OFF_CYC ((`FRINT_CLK_HZ / 1000) * `FRINT_T_OFF_MS)
`define FRINT_BLINK_CYC     6250000
`define FRINT_TMR_W         24
`define FRINT_SENSE_LAT     4
`define FRINT_ADDR_CTRL     4'h0
`define FRINT_ADDR_STAT     4'h1
`define FRINT_ADDR_IRQ      4'h2
`define FRINT_ADDR_MASK     4'h3
`define FRINT_CTRL_RST      8'h00
`define FRINT_B_FBEN        0
`define FRINT_B_MANUAL      1
`define FRINT_B_CODE_LO     2
`define FRINT_B_CODE_HI     3
`define FRINT_EV_W          4
`define FRINT_EV_FB         0
`define FRINT_EV_FAULT      1
`define FRINT_EV_SHORT      2
`define FRINT_EV_STOP       3
`define FRINT_CODE_NONE     2'h0
`endif

// >>> design/frint_pkg.sv
// types for the feedback restart interlock
package frint_pkg;
  typedef enum logic [1:0] {
    FRINT_ST_OFF  = 2'b00,
    FRINT_ST_ON   = 2'b01,
    FRINT_ST_WAIT = 2'b11,
    FRINT_ST_LOCK = 2'b10
  } frint_state_e;
endpackage : frint_pkg

// >>> design/frint_sync.sv
// three flip-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module frint_sync
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_d,
  output logic      o_q
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // chain; output follows once second and third stages agree
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      o_q    <= 1'b0;
    end
    else
    begin
      s1_reg <= i_d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg)
        o_q <= s3_reg;
    end
  end
endmodule : frint_sync

// >>> design/frint_top.sv
// feedback supervision and restart interlock of the receiver
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "frint_defines.svh"
module frint_top
  import frint_pkg::*;
#(
  parameter int ON_CYC  = `FRINT_ON_CYC,
  parameter int OFF_CYC = `FRINT_OFF_CYC,
  parameter int BLINK_CYC = `FRINT_BLINK_CYC
)
(
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic [3:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic [31:0]      O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  input  wire logic        I_FIELD_CLEAR,
  input  wire logic [1:0]  I_RX_BEAM_CODE,
  input  wire logic        I_INT_FAULT,
  input  wire logic        I_FEEDBACK,
  input  wire logic        I_START_BUTTON,
  input  wire logic        I_TEST_INPUT,
  input  wire logic        I_SENSE_A,
  input  wire logic        I_SENSE_B,
  output logic             O_SAFETY_OUTPUT_A,
  output logic             O_SAFETY_OUTPUT_B,
  output logic [1:0]       O_TX_BEAM_CODE,
  output logic [1:0]       O_CODE_LED,
  output logic             O_GREEN_A,
  output logic             O_RED_A,
  output logic             O_GREEN_B,
  output logic             O_RED_B,
  output logic             O_BLOCKED_INDICATOR,
  output logic             O_TX_BLOCKED_INDICATOR,
  output logic             O_TEST_MODE,
  output logic             O_TEST_LED,
  output logic             O_IRQ
);
  //**************************************************************
  // input synchronisers
  //**************************************************************
  logic fb_s;
  logic start_s;
  logic test_s;
  logic sense_a_s;
  logic sense_b_s;
  logic start_d_reg;
  logic start_edge;

  frint_sync u_sync_fb
    (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_d(I_FEEDBACK), .o_q(fb_s));
  frint_sync u_sync_start
    (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_d(I_START_BUTTON), .o_q(start_s));
  frint_sync u_sync_test
    (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_d(I_TEST_INPUT), .o_q(test_s));
  frint_sync u_sync_sa
    (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_d(I_SENSE_A), .o_q(sense_a_s));
  frint_sync u_sync_sb
    (.i_clk(I_CLK_SYS), .i_rst(I_RST), .i_d(I_SENSE_B), .o_q(sense_b_s));
  // start press detected on rising edge of the filtered button
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      start_d_reg <= 1'b0;
    else
      start_d_reg <= start_s;
  end
  assign start_edge = start_s & ~start_d_reg;

  //**************************************************************
  // register slave
  //**************************************************************
  logic [7:0]              ctrl_reg;
  logic [`FRINT_EV_W-1:0]  irq_reg;
  logic [`FRINT_EV_W-1:0]  mask_reg;
  logic [`FRINT_EV_W-1:0]  ev;
  logic                    wr_ctrl;
  logic                    wr_irq;
  logic                    wr_mask;
  logic                    fb_en;
  logic                    manual;
  logic [1:0]              code;
  frint_state_e            state_reg;
  frint_state_e            state_next;
  logic                    outs_on;
  logic                    field_ok;
  logic                    short_det;
  logic                    rd_ack_reg;

  // reads stall one cycle so registered data stands at the take edge
  assign O_AVS_WAITREQUEST = I_AVS_READ & ~rd_ack_reg;
  assign wr_ctrl = I_AVS_WRITE & (I_AVS_ADDRESS == `FRINT_ADDR_CTRL);
  assign wr_irq  = I_AVS_WRITE & (I_AVS_ADDRESS == `FRINT_ADDR_IRQ);
  assign wr_mask = I_AVS_WRITE & (I_AVS_ADDRESS == `FRINT_ADDR_MASK);
  assign fb_en   = ctrl_reg[`FRINT_B_FBEN];
  assign manual  = ctrl_reg[`FRINT_B_MANUAL];
  assign code    = ctrl_reg[`FRINT_B_CODE_HI:`FRINT_B_CODE_LO];

  // configuration: feedback off, automatic, code zero after reset
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      ctrl_reg <= `FRINT_CTRL_RST;
    else if (wr_ctrl)
      ctrl_reg <= I_AVS_WRITEDATA[7:0];
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      irq_reg <= '0;
    else if (wr_irq)
      irq_reg <= (irq_reg & ~I_AVS_WRITEDATA[`FRINT_EV_W-1:0]) | ev;
    else
      irq_reg <= irq_reg | ev;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      mask_reg <= '0;
    else if (wr_mask)
      mask_reg <= I_AVS_WRITEDATA[`FRINT_EV_W-1:0];
  end

  // read data registered; unmapped offsets read zero; one wait state
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      O_AVS_READDATA <= '0;
      rd_ack_reg     <= 1'b0;
    end
    else
    begin
      rd_ack_reg <= I_AVS_READ & ~rd_ack_reg;
      if (I_AVS_READ)
      begin
        unique case (I_AVS_ADDRESS)
          `FRINT_ADDR_CTRL: O_AVS_READDATA <= {24'h0, ctrl_reg};
          `FRINT_ADDR_STAT: O_AVS_READDATA <= {26'h0, short_det, fb_s,
                                               field_ok, outs_on,
                                               state_reg};
          `FRINT_ADDR_IRQ:  O_AVS_READDATA <= {28'h0, irq_reg};
          `FRINT_ADDR_MASK: O_AVS_READDATA <= {28'h0, mask_reg};
          default:          O_AVS_READDATA <= '0;
        endcase
      end
    end
  end
  assign O_IRQ = |(irq_reg & mask_reg);

  //**************************************************************
  // beam coding
  //**************************************************************
  // sender marks beams; receiver accepts only when codes match
  assign O_TX_BEAM_CODE = code;
  assign O_CODE_LED     = code;
  assign field_ok = I_FIELD_CLEAR & (I_RX_BEAM_CODE == code)
                  & (code != 2'h3);

  //**************************************************************
  // feedback window timer
  //**************************************************************
  logic                    outs_d_reg;
  logic [`FRINT_TMR_W-1:0] tmr_reg;
  logic                    tmr_run_reg;
  logic                    fb_err;
  logic                    fb_err_d_reg;
  // previous output state and mismatch, for edge detection
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      outs_d_reg   <= 1'b0;
      fb_err_d_reg <= 1'b0;
    end
    else
    begin
      outs_d_reg   <= outs_on;
      fb_err_d_reg <= fb_err;
    end
  end
  // restart on each edge; on-window or off-window length
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      tmr_reg     <= '0;
      tmr_run_reg <= 1'b0;
    end
    else if (outs_on != outs_d_reg)
    begin
      tmr_run_reg <= 1'b1;
      tmr_reg <= outs_on ? `FRINT_TMR_W'(ON_CYC - 1)
                         : `FRINT_TMR_W'(OFF_CYC - 1);
    end
    else if (tmr_run_reg && tmr_reg != '0)
      tmr_reg <= tmr_reg - 1'b1;
    else
      tmr_run_reg <= 1'b0;
  end

  // mismatch: feedback equal to output level after window
  assign fb_err = fb_en & ~tmr_run_reg & (fb_s == outs_d_reg)
                & (outs_on == outs_d_reg);

  //**************************************************************
  // short detection
  //**************************************************************
  logic [`FRINT_SENSE_LAT-1:0] drv_dly_reg;
  // read-back against drive delayed by the synchroniser latency
  assign short_det = (sense_a_s != drv_dly_reg[`FRINT_SENSE_LAT-1])
                   | (sense_b_s != drv_dly_reg[`FRINT_SENSE_LAT-1]);

  //**************************************************************
  // interlock state machine
  //**************************************************************
  logic fault_latch_reg;

  // internal fault locks until power cycle (reset)
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      fault_latch_reg <= 1'b0;
    else if (I_INT_FAULT)
      fault_latch_reg <= 1'b1;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      FRINT_ST_OFF:
        if (field_ok && !short_det)
          state_next = manual ? FRINT_ST_WAIT : FRINT_ST_ON;
      FRINT_ST_ON:
        if (!field_ok || short_det || fb_err)
          state_next = FRINT_ST_OFF;
      FRINT_ST_WAIT:
        if (!field_ok || short_det)
          state_next = FRINT_ST_OFF;
        else if (start_edge)
          state_next = FRINT_ST_ON;
      FRINT_ST_LOCK:
        state_next = FRINT_ST_LOCK;
    endcase
    if (fault_latch_reg || I_INT_FAULT)
      state_next = FRINT_ST_LOCK;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
      state_reg <= FRINT_ST_OFF;
    else
      state_reg <= state_next;
  end

  assign outs_on = (state_reg == FRINT_ST_ON);

  // events for the sticky status
  assign ev[`FRINT_EV_FB]    = fb_err & ~fb_err_d_reg;
  assign ev[`FRINT_EV_FAULT] = I_INT_FAULT & ~fault_latch_reg;
  assign ev[`FRINT_EV_SHORT] = short_det & outs_on;
  assign ev[`FRINT_EV_STOP]  = outs_on & (state_next != FRINT_ST_ON);

  //**************************************************************
  // outputs and indication
  //**************************************************************
  logic [22:0] blink_cnt_reg;
  logic        blink_reg;

  // blink divider for the blocked indicator
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end
    else if (blink_cnt_reg == 23'(BLINK_CYC - 1))
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
  end

  // registered drives and indicators
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      O_SAFETY_OUTPUT_A      <= 1'b0;
      O_SAFETY_OUTPUT_B      <= 1'b0;
      O_GREEN_A              <= 1'b0;
      O_RED_A                <= 1'b1;
      O_GREEN_B              <= 1'b0;
      O_RED_B                <= 1'b1;
      O_BLOCKED_INDICATOR    <= 1'b0;
      O_TX_BLOCKED_INDICATOR <= 1'b0;
      O_TEST_MODE            <= 1'b1;
      O_TEST_LED             <= 1'b1;
      drv_dly_reg            <= '0;
    end
    else
    begin
      O_SAFETY_OUTPUT_A <= outs_on;
      O_SAFETY_OUTPUT_B <= outs_on;
      O_GREEN_A <= outs_on;
      O_RED_A   <= ~outs_on;
      O_GREEN_B <= outs_on;
      O_RED_B   <= ~outs_on;
      O_BLOCKED_INDICATOR <= (state_reg == FRINT_ST_WAIT)
                           & blink_reg;
      O_TX_BLOCKED_INDICATOR <= ~I_FIELD_CLEAR;
      O_TEST_MODE <= ~test_s;
      O_TEST_LED  <= ~test_s;
      drv_dly_reg <= {drv_dly_reg[`FRINT_SENSE_LAT-2:0], O_SAFETY_OUTPUT_A};
    end
  end

  //**************************************************************
  // assertions
  //**************************************************************
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  sequence s_drop;
    outs_on ##1 !outs_on;
  endsequence

  obstr_off_a: assert property (!field_ok |=> !outs_on)
    else $error("outputs on while field obstructed");
  lock_hold_a: assert property (fault_latch_reg |-> ##1
    (!outs_on)[*8])
    else $error("outputs on after fault latch");
  short_off_a: assert property (short_det |=> !outs_on)
    else $error("outputs on during short");
  fb_drop_a: assert property (fb_err && outs_on |=> !outs_on)
    else $error("feedback mismatch did not drop outputs");
  manual_wait_a: assert property (s_drop ##0 manual |->
    ##1 (!outs_on || $past(start_edge)))
    else $error("manual restart without start");
  auto_on_a: assert property (state_reg == FRINT_ST_OFF && field_ok
    && !short_det && !manual && !fault_latch_reg && !I_INT_FAULT
    |=> outs_on)
    else $error("automatic restart missing");
  tmr_load_a: assert property ($rose(outs_on) |=> tmr_run_reg &&
    tmr_reg == `FRINT_TMR_W'(ON_CYC - 1))
    else $error("on window not loaded");
  tmr_off_a: assert property ($fell(outs_on) |=> tmr_run_reg &&
    tmr_reg == `FRINT_TMR_W'(OFF_CYC - 1))
    else $error("off window not loaded");
  fb_ignore_a: assert property (!fb_en |-> !fb_err)
    else $error("feedback checked while disabled");
  led_a: assert property (##1 O_GREEN_A == $past(outs_on)
    && O_RED_A == !O_GREEN_A)
    else $error("indicator does not follow output");
endmodule : frint_top

// >>> bench/frint_contactor_model.sv
// contactor model returning its feedback contacts to the receiver
`timescale 1ns/1ps
module frint_contactor_model
(
  input  wire logic       i_clk,
  input  wire logic       i_drive,
  input  wire logic       i_stick,
  input  wire logic [4:0] i_delay,
  output logic            o_feedback
);
  logic [31:0] hist_reg = '0;
  initial o_feedback = 1'b1;
  // drive history, one bit per cycle
  always @(posedge i_clk)
  begin
    hist_reg <= {hist_reg[30:0], i_drive};
  end
  // contacts follow the inverse drive after a delay unless welded
  always @(posedge i_clk)
  begin
    if (!i_stick)
    begin
      o_feedback <= ~hist_reg[i_delay];
    end
  end
endmodule : frint_contactor_model

// >>> bench/test_feedback_restart_interlock.sv
// self-checking bench of the feedback restart interlock
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fail_count++; \
      $display("wrong value at %0t: %h vs %h", $time, got, exp); \
    end \
  end
module test_feedback_restart_interlock;
  logic clk = 0, rst = 1, rd = 0, wr = 0, field = 0, fault = 0;
  logic start = 0, test_in = 0, stick = 0, short_inj = 0, fb, irq;
  logic out_a, out_b, grn_a, red_a, grn_b, red_b, blk, tx_blk, tmode;
  logic wreq, tled;
  logic [3:0]  addr = '0;
  logic [31:0] wdata = '0, rdata, rd_q;
  logic [1:0]  rx = '0, tx_code, led;
  logic [4:0]  dly = 5'h01;
  int fail_count = 0, samples_checked = 0, k;
  logic seen;
  //****************************************************************
  // clock, design and contactor model
  //****************************************************************
  // 25 mhz system clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  frint_top #(.ON_CYC(20), .OFF_CYC(10), .BLINK_CYC(4)) frint_top_i (
    .I_CLK_SYS(clk), .I_RST(rst), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq), .I_FIELD_CLEAR(field), .I_RX_BEAM_CODE(rx),
    .I_INT_FAULT(fault), .I_FEEDBACK(fb), .I_START_BUTTON(start),
    .I_TEST_INPUT(test_in), .I_SENSE_A(out_a ^ short_inj),
    .I_SENSE_B(out_b), .O_SAFETY_OUTPUT_A(out_a), .O_SAFETY_OUTPUT_B(out_b),
    .O_TX_BEAM_CODE(tx_code), .O_CODE_LED(led), .O_GREEN_A(grn_a),
    .O_RED_A(red_a), .O_GREEN_B(grn_b), .O_RED_B(red_b),
    .O_BLOCKED_INDICATOR(blk), .O_TX_BLOCKED_INDICATOR(tx_blk),
    .O_TEST_MODE(tmode), .O_TEST_LED(tled), .O_IRQ(irq));
  frint_contactor_model frint_contactor_model_i (.i_clk(clk),
    .i_drive(out_a), .i_stick(stick), .i_delay(dly), .o_feedback(fb));
  //****************************************************************
  // tasks
  //****************************************************************
  // prints counts and verdict, then stops
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  // holds the request until waitrequest is sampled low
  task automatic bus_cycle(input logic [3:0] a, input logic w,
                           input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do
    begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    rd_q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      finish_test();
    end
  endtask : bus_cycle
  // read data taken at the edge where waitrequest is sampled low
  task automatic bus_read(input logic [3:0] a, input logic [31:0] e,
                          input logic [31:0] m);
    bus_cycle(a, 1'b0, '0);
    `CHK(rd_q & m, e)
  endtask : bus_read
  // waits a bounded time for output A to reach a level, then checks both
  task automatic wait_out(input logic v, input int n);
    k = 0;
    while (out_a !== v && k < n)
    begin
      @(posedge clk);
      k++;
    end
    `CHK({out_a, out_b}, {v, v})
  endtask : wait_out
  // both outputs must keep a level for n cycles
  task automatic hold_out(input logic v, input int n);
    repeat (n)
    begin
      @(posedge clk);
      `CHK({out_a, out_b}, {v, v})
    end
  endtask : hold_out
  // synchronous reset held for 12 cycles
  task automatic do_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset
  //****************************************************************
  // main sequence
  //****************************************************************
  // scenarios run in order, each from a known state
  initial
  begin
    do_reset();
    bus_read(4'h0, 32'h0, 32'hff);
    bus_read(4'hf, 32'h0, 32'hffffffff);
    `CHK({tmode, out_a, red_a, red_b}, 4'hb)
    test_in <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({tmode, tled}, 2'h0)
    field <= 1'b1;
    wait_out(1'b1, 20);
    `CHK({grn_a, red_a, grn_b, red_b}, 4'ha)
    @(posedge clk) field <= 1'b0;
    wait_out(1'b0, 6);
    `CHK({tx_blk, red_a, red_b}, 3'h7)
    @(posedge clk) field <= 1'b1;
    wait_out(1'b1, 20);
    for (int c = 1; c < 3; c++)
    begin
      bus_cycle(4'h0, 1'b1, 32'(c << 2));
      wait_out(1'b0, 10);
      `CHK({tx_code, led}, {2'(c), 2'(c)})
      rx <= 2'(c);
      wait_out(1'b1, 20);
    end
    bus_cycle(4'h0, 1'b1, 32'h0c);
    rx <= 2'h3;
    wait_out(1'b0, 10);
    hold_out(1'b0, 10);
    rx <= 2'h2;
    bus_cycle(4'h0, 1'b1, 32'h0a);
    @(posedge clk) field <= 1'b0;
    wait_out(1'b0, 6);
    @(posedge clk) field <= 1'b1;
    seen = 1'b0;
    repeat (30)
    begin
      @(posedge clk);
      seen |= blk;
      `CHK({out_a, out_b, red_a}, 3'h1)
    end
    `CHK(seen, 1'b1)
    start <= 1'b1;
    wait_out(1'b1, 20);
    start <= 1'b0;
    bus_cycle(4'h0, 1'b1, 32'h09);
    bus_cycle(4'h3, 1'b1, 32'h1);
    hold_out(1'b1, 60);
    @(posedge clk) field <= 1'b0;
    wait_out(1'b0, 6);
    repeat (20) @(posedge clk);
    dly <= 5'h0c;
    field <= 1'b1;
    wait_out(1'b1, 20);
    hold_out(1'b1, 40);
    stick <= 1'b1;
    field <= 1'b0;
    wait_out(1'b0, 6);
    k = 0;
    while (irq !== 1'b1 && k < 22)
    begin
      @(posedge clk);
      k++;
    end
    `CHK(irq, 1'b1)
    bus_read(4'h2, 32'h1, 32'h1);
    bus_cycle(4'h3, 1'b1, 32'h0);
    @(posedge clk);
    `CHK(irq, 1'b0)
    bus_cycle(4'h2, 1'b1, 32'hf);
    bus_read(4'h2, 32'h0, 32'h1);
    do_reset();
    dly <= 5'h01;
    rx <= 2'h0;
    stick <= 1'b0;
    repeat (4) @(posedge clk);
    stick <= 1'b1;
    field <= 1'b1;
    wait_out(1'b1, 20);
    hold_out(1'b1, 60);
    bus_cycle(4'h0, 1'b1, 32'h01);
    @(posedge clk) field <= 1'b0;
    wait_out(1'b0, 6);
    @(posedge clk) field <= 1'b1;
    wait_out(1'b1, 20);
    wait_out(1'b0, 32);
    bus_read(4'h2, 32'h1, 32'h1);
    do_reset();
    stick <= 1'b0;
    wait_out(1'b1, 30);
    short_inj <= 1'b1;
    wait_out(1'b0, 10);
    hold_out(1'b0, 20);
    bus_read(4'h2, 32'h4, 32'h4);
    short_inj <= 1'b0;
    do_reset();
    wait_out(1'b1, 30);
    fault <= 1'b1;
    @(posedge clk) fault <= 1'b0;
    wait_out(1'b0, 6);
    hold_out(1'b0, 30);
    bus_read(4'h1, 32'h2, 32'h3);
    bus_read(4'h2, 32'h2, 32'h2);
    finish_test();
  end
endmodule : test_feedback_restart_interlock
